// ===== rtl/ocpwm_channel_bank.sv
// Contract
// - eight independent channels, each with its own 16-bit control register
// - control bit 3 picks one of two 16-bit timers as time base
// - timebase select at default zero picks timer 2
// - mode 001 drives low, 010 high, 011 toggles on match
// - single-compare matches primary against up-counting selected timer
// - timer wrap before match leaves the pin unchanged
// - dual-compare uses primary for first match, secondary for second
// - mode 100 gives one pulse, 101 a continuous pulse train
// - pulse starts at primary match, ends at secondary match
// - no further single pulse until mode 100 is written again
// - continuous mode repeats the pulse every timer period
// - mode 110 plain PWM, 111 PWM with fault protection
// - in PWM primary is read-only duty latch, software writes secondary
// - on period rollover clear timer, set pin unless new duty is zero, latch duty, flag timer
// - fault low in mode 111 floats pin, sets fault until mode rewritten with fault pin high
// - non-PWM compare events set compare flag; PWM uses timer flag
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`default_nettype none
module ocpwm_channel_bank #(
	parameter int unsigned NCH = ocpwm_pkg::NUM_CH
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// avalon-mm slave
	input  wire logic [7:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic      [31:0]       avs_readdata,
	output logic                   avs_waitrequest,
	// timer bases (timer 2 and timer 3), same clock domain
	input  wire ocpwm_pkg::ocpwm_timer_t tmr2,
	input  wire ocpwm_pkg::ocpwm_timer_t tmr3,
	// fault pins, active low, asynchronous
	input  wire logic [NCH-1:0]    fault_input_pin_n,
	// compare outputs; oe low means driven
	output logic      [NCH-1:0]    compare_output_pin,
	output logic      [NCH-1:0]    compare_output_pin_oe_n,
	// pulse flags to interrupt controller
	output logic      [NCH-1:0]    compare_irq_flag,
	output logic      [1:0]        timer_irq_flag
);
	typedef struct packed {
		ocpwm_pkg::ocpwm_ch_t [NCH-1:0] ch;
		logic [NCH-1:0]                 f_s1;
		logic [NCH-1:0]                 f_s2;
		logic [31:0]                    rdata;
		logic                           ack;
		logic                           wreq;
		logic [NCH-1:0]                 cirq;
		logic [1:0]                     tirq;
	} ocpwm_state_t;

	ocpwm_state_t st_r, st_nxt;

	// rollover: count equals period on a running timer, next increment clears
	function automatic logic ocpwm_roll(input ocpwm_pkg::ocpwm_timer_t t);
		return t.run && (t.count == t.period);
	endfunction : ocpwm_roll

	function automatic logic [15:0] ocpwm_ctrl(input ocpwm_pkg::ocpwm_ch_t c);
		logic [15:0] v;
		v = ocpwm_pkg::CTRL_RESET;
		v[ocpwm_pkg::MODE_LSB +: 3] = c.mode;
		v[ocpwm_pkg::TSEL_BIT]      = c.tsel;
		v[ocpwm_pkg::FAULT_BIT]     = c.fault;
		v[ocpwm_pkg::IRQ_BIT]       = c.irq;
		return v;
	endfunction : ocpwm_ctrl

	always_comb begin
		ocpwm_pkg::ocpwm_timer_t t;
		logic                    roll;
		logic                    match1;
		logic                    match2;
		logic                    wr;
		logic                    wmode;
		logic [3:0]              idx;
		logic [7:0]              sub;
		logic [15:0]             wd;
		t      = tmr2;
		roll   = 1'b0;
		match1 = 1'b0;
		match2 = 1'b0;
		wr     = 1'b0;
		wmode  = 1'b0;
		idx    = avs_address[7:4];
		sub    = {4'h0, avs_address[3:0]};
		wd     = avs_writedata[15:0];
		st_nxt = st_r;
		st_nxt.f_s1 = ~fault_input_pin_n;
		st_nxt.f_s2 = st_r.f_s1;
		st_nxt.cirq = '0;
		st_nxt.ack  = 1'b0;
		st_nxt.rdata = ocpwm_pkg::UNMAPPED_RD;
		if ((avs_read || avs_write) && !st_r.ack) begin
			st_nxt.ack = 1'b1;
			if (avs_read && idx < 4'(NCH)) begin
				case (sub)
					ocpwm_pkg::OFF_SECONDARY: st_nxt.rdata = {16'h0000, st_r.ch[idx].secondary};
					ocpwm_pkg::OFF_PRIMARY:   st_nxt.rdata = {16'h0000, st_r.ch[idx].primary};
					ocpwm_pkg::OFF_CONTROL:   st_nxt.rdata = {16'h0000, ocpwm_ctrl(st_r.ch[idx])};
					default:                  st_nxt.rdata = ocpwm_pkg::UNMAPPED_RD;
				endcase
			end
		end
		for (int i = 0; i < NCH; i++) begin
			t      = st_r.ch[i].tsel ? tmr3 : tmr2;
			roll   = ocpwm_roll(t);
			match1 = t.run && (t.count == st_r.ch[i].primary);
			match2 = t.run && (t.count == st_r.ch[i].secondary);
			wr     = avs_write && st_r.ack && idx == 4'(i) && (avs_byteenable[1:0] != 2'b00);
			wmode  = 1'b0;
			case (st_r.ch[i].mode)
				ocpwm_pkg::OCPWM_OFF: begin
					st_nxt.ch[i].done = 1'b0;
				end
				ocpwm_pkg::OCPWM_LOW, ocpwm_pkg::OCPWM_HIGH, ocpwm_pkg::OCPWM_TOGGLE: begin
					// wrap without match changes nothing
					if (match1) begin
						st_nxt.cirq[i] = 1'b1;
						case (st_r.ch[i].mode)
							ocpwm_pkg::OCPWM_LOW:  st_nxt.ch[i].pin = 1'b0;
							ocpwm_pkg::OCPWM_HIGH: st_nxt.ch[i].pin = 1'b1;
							default:               st_nxt.ch[i].pin = ~st_r.ch[i].pin;
						endcase
					end
				end
				ocpwm_pkg::OCPWM_SINGLE, ocpwm_pkg::OCPWM_CONT: begin
					if (match1 && !st_r.ch[i].done) begin
						st_nxt.ch[i].pin = 1'b1;
						st_nxt.cirq[i]   = 1'b1;
					end
					if (match2 && st_r.ch[i].pin) begin
						st_nxt.ch[i].pin = 1'b0;
						st_nxt.cirq[i]   = 1'b1;
						if (st_r.ch[i].mode == ocpwm_pkg::OCPWM_SINGLE) begin
							st_nxt.ch[i].done = 1'b1;
						end
					end
					// continuous mode never sets done, so each period repeats
				end
				ocpwm_pkg::OCPWM_PWM, ocpwm_pkg::OCPWM_PWMF: begin
					if (st_r.ch[i].mode == ocpwm_pkg::OCPWM_PWMF && st_r.f_s2[i]) begin
						st_nxt.ch[i].fault = 1'b1;
					end
					if (roll) begin
						st_nxt.ch[i].primary = st_r.ch[i].secondary;
						st_nxt.ch[i].pin     = (st_r.ch[i].secondary != 16'h0000);
					end else if (match1 && st_r.ch[i].primary <= t.period) begin
						st_nxt.ch[i].pin = 1'b0;
					end
				end
				default: begin
					st_nxt.ch[i].done = st_r.ch[i].done;
				end
			endcase
			if (st_r.ch[i].irq) begin
				st_nxt.ch[i].irq = 1'b1;
			end
			if (st_nxt.cirq[i]) begin
				st_nxt.ch[i].irq = 1'b1;
			end
			if (wr) begin
				case (sub)
					ocpwm_pkg::OFF_SECONDARY: st_nxt.ch[i].secondary = wd;
					ocpwm_pkg::OFF_PRIMARY: begin
						if (!st_r.ch[i].mode[2] || !st_r.ch[i].mode[1]) begin
							st_nxt.ch[i].primary = wd;
						end
					end
					ocpwm_pkg::OFF_CONTROL: begin
						wmode = 1'b1;
						st_nxt.ch[i].mode = ocpwm_pkg::ocpwm_mode_t'(wd[ocpwm_pkg::MODE_LSB +: 3]);
						st_nxt.ch[i].tsel = wd[ocpwm_pkg::TSEL_BIT];
						st_nxt.ch[i].done = 1'b0;
						// writing one clears the sticky flag unless an event lands now
						if (wd[ocpwm_pkg::IRQ_BIT] && !st_nxt.cirq[i]) begin
							st_nxt.ch[i].irq = 1'b0;
						end
						// fault stays while the pin is still low
						if (!st_r.f_s2[i]) begin
							st_nxt.ch[i].fault = 1'b0;
						end
					end
					default: begin
						wmode = 1'b0;
					end
				endcase
			end
			if (wmode && wd[2:0] == 3'b000) begin
				st_nxt.ch[i].pin = 1'b0;
			end
		end
		st_nxt.tirq = {ocpwm_roll(tmr3), ocpwm_roll(tmr2)};
		// waitrequest kept as its own flop so the port comes straight from a register
		st_nxt.wreq = !st_nxt.ack;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NCH; i++) begin
				st_r.ch[i].primary   <= ocpwm_pkg::CMP_RESET;
				st_r.ch[i].secondary <= ocpwm_pkg::CMP_RESET;
				st_r.ch[i].mode      <= ocpwm_pkg::OCPWM_OFF;
				st_r.ch[i].tsel      <= 1'b0;
				st_r.ch[i].fault     <= 1'b0;
				st_r.ch[i].irq       <= 1'b0;
				st_r.ch[i].pin       <= 1'b0;
				st_r.ch[i].done      <= 1'b0;
			end
			st_r.f_s1  <= '0;
			st_r.f_s2  <= '0;
			st_r.rdata <= 32'h0000_0000;
			st_r.ack   <= 1'b0;
			st_r.wreq  <= 1'b1;
			st_r.cirq  <= '0;
			st_r.tirq  <= 2'b00;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			compare_output_pin[i]      = st_r.ch[i].pin;
			compare_output_pin_oe_n[i] = st_r.ch[i].fault;
		end
	end

	assign avs_readdata     = st_r.rdata;
	assign avs_waitrequest  = st_r.wreq;
	assign compare_irq_flag = st_r.cirq;
	assign timer_irq_flag   = st_r.tirq;
endmodule : ocpwm_channel_bank
`default_nettype wire

// ===== rtl/ocpwm_pkg.sv
`default_nettype none
package ocpwm_pkg;
	localparam int unsigned NUM_CH      = 8;
	localparam int unsigned DATA_W      = 16;
	// register index per channel: secondary, primary, control; channel stride 4 words
	localparam logic [7:0] OFF_SECONDARY = 8'h00;
	localparam logic [7:0] OFF_PRIMARY   = 8'h04;
	localparam logic [7:0] OFF_CONTROL   = 8'h08;
	localparam logic [7:0] OFF_CH_STRIDE = 8'h10;
	// control field positions
	localparam int unsigned MODE_LSB    = 0;
	localparam int unsigned TSEL_BIT    = 3;
	localparam int unsigned FAULT_BIT   = 4;
	localparam int unsigned IRQ_BIT     = 5;
	localparam logic [15:0] CTRL_RESET  = 16'h0000;
	localparam logic [15:0] CMP_RESET   = 16'h0000;
	localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
	typedef enum logic [2:0] {
		OCPWM_OFF    = 3'b000,
		OCPWM_LOW    = 3'b001,
		OCPWM_HIGH   = 3'b010,
		OCPWM_TOGGLE = 3'b011,
		OCPWM_SINGLE = 3'b100,
		OCPWM_CONT   = 3'b101,
		OCPWM_PWM    = 3'b110,
		OCPWM_PWMF   = 3'b111
	} ocpwm_mode_t;
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] period;
		logic        run;
	} ocpwm_timer_t;
	typedef struct packed {
		logic [15:0]  primary;
		logic [15:0]  secondary;
		ocpwm_mode_t  mode;
		logic         tsel;
		logic         fault;
		logic         irq;
		logic         pin;
		logic         done;
	} ocpwm_ch_t;
endpackage : ocpwm_pkg
`default_nettype wire

// ===== verif/ocpwm_props.sv
`default_nettype none
module ocpwm_props #(
	parameter int unsigned NCH = 8
) (
	// clock and reset
	input wire logic                    clk_sys,
	input wire logic                    rst,
	// bus
	input wire logic [7:0]              avs_address,
	input wire logic                    avs_read,
	input wire logic                    avs_write,
	input wire logic [31:0]             avs_writedata,
	input wire logic                    avs_waitrequest,
	// timers and pins
	input wire ocpwm_pkg::ocpwm_timer_t tmr2,
	input wire ocpwm_pkg::ocpwm_timer_t tmr3,
	input wire logic [NCH-1:0]          fault_input_pin_n,
	input wire logic [NCH-1:0]          compare_output_pin,
	input wire logic [NCH-1:0]          compare_output_pin_oe_n,
	input wire logic [NCH-1:0]          compare_irq_flag,
	input wire logic [1:0]              timer_irq_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] m0_r;
	logic [2:0] m0_q_r;
	logic       hit2;
	assign hit2 = tmr2.run && tmr2.count == tmr2.period;
	// channel 0 mode as last written
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			m0_r <= 3'h0;
			m0_q_r <= 3'h0;
		end else begin
			if (avs_write && !avs_waitrequest && avs_address == 8'h08)
				m0_r <= avs_writedata[2:0];
			m0_q_r <= m0_r;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer");
	a_bus_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer too long");
	a_tmr_set: assert property (hit2 |=> timer_irq_flag[0])
		else $error("timer flag missing");
	a_tmr_clear: assert property (!hit2 |=> !timer_irq_flag[0])
		else $error("timer flag stray");
	a_tmr_cause: assert property (timer_irq_flag[1] |-> $past(tmr3.run) && $past(tmr3.count) == $past(tmr3.period))
		else $error("timer 3 flag stray");
	a_pwm_quiet: assert property (m0_r[2:1] == 2'b11 && m0_q_r[2:1] == 2'b11 |-> !compare_irq_flag[0])
		else $error("compare flag in pwm");
	a_off_quiet: assert property (m0_r == 3'h0 && m0_q_r == 3'h0 |-> !compare_output_pin[0] && !compare_irq_flag[0])
		else $error("activity when off");
	a_fault_float: assert property ((m0_r == 3'h7 && !fault_input_pin_n[0]) [*4] |=> compare_output_pin_oe_n[0])
		else $error("pin not floated");
	a_fault_hold: assert property (compare_output_pin_oe_n[0] && !avs_write |=> compare_output_pin_oe_n[0])
		else $error("float dropped");
endmodule : ocpwm_props
bind ocpwm_channel_bank ocpwm_props #(.NCH(NCH)) i_props (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_waitrequest, .tmr2, .tmr3, .fault_input_pin_n, .compare_output_pin,
	.compare_output_pin_oe_n, .compare_irq_flag, .timer_irq_flag);
`default_nettype wire

// ===== verif/ocpwm_load.sv
`default_nettype none
module ocpwm_load (
	// driven pin
	input  wire logic pin,
	input  wire logic pin_oe_n,
	// overcurrent request
	input  wire logic trip,
	// line and fault sense
	output logic      level,
	output logic      fault_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// pull-down holds a floating line
	assign level = pin_oe_n ? 1'b0 : pin;
	assign fault_n = !trip;
endmodule : ocpwm_load
`default_nettype wire

// ===== verif/tb_output_compare_pwm_channel.sv
`default_nettype none
module tb_output_compare_pwm_channel;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s exp %h got %h", n, e, g); end end
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata, q;
	logic avs_waitrequest, trip = 1'b0, fault0_n, lvl0;
	ocpwm_pkg::ocpwm_timer_t tm [2] = '{default: '0};
	logic [7:0] pin, oe_n, cirq;
	logic [1:0] tirq;
	int mismatches = 0;
	int compares = 0;
	int cyc = 0;
	always #5 clk_sys = !clk_sys;
	always @(posedge clk_sys) begin
		for (int i = 0; i < 2; i++)
			tm[i].count <= !tm[i].run || tm[i].count == tm[i].period ? 16'h0000 : tm[i].count + 16'h0001;
		if (++cyc == 3000) begin
			mismatches++;
			test_done();
		end
	end
	ocpwm_channel_bank i_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .tmr2(tm[0]), .tmr3(tm[1]),
		.fault_input_pin_n({7'h7f, fault0_n}), .compare_output_pin(pin), .compare_output_pin_oe_n(oe_n),
		.compare_irq_flag(cirq), .timer_irq_flag(tirq));
	ocpwm_load i_load (.pin(pin[0]), .pin_oe_n(oe_n[0]), .trip, .level(lvl0), .fault_n(fault0_n));
	task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic t_regs;
		bus(0, 8'h38, 16'h0000);
		`CHK("ctrl reset", 32'h0000_0000, q)
		bus(1, 8'h30, 16'hbeef);
		bus(0, 8'h30, 16'h0000);
		`CHK("secondary", 32'h0000_beef, q)
		bus(0, 8'h0c, 16'h0000);
		`CHK("unmapped", 32'h0000_0000, q)
	endtask : t_regs
	task automatic t_single;
		logic [2:0] md [4] = '{3'h2, 3'h3, 3'h2, 3'h1};
		logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
		tm[1].period <= 16'h0014;
		bus(1, 8'h14, 16'h0005);
		for (int i = 0; i < 4; i++) begin
			tm[1].run <= 1'b0;
			bus(1, 8'h18, {12'h000, 1'b1, md[i]});
			tm[1].run <= 1'b1;
			do @(posedge clk_sys); while (cirq[1] !== 1'b1);
			`CHK("single pin", ex[i], pin[1])
		end
		bus(1, 8'h14, 16'h0030);
		bus(1, 8'h18, 16'h000b);
		repeat (60) @(posedge clk_sys);
		`CHK("wrap pin", 1'b0, pin[1])
	endtask : t_single
	task automatic t_dual(input logic [2:0] md, input int hi, input int evx);
		int h = 0;
		int ev = 0;
		tm[0].run <= 1'b0;
		bus(1, 8'h04, 16'h0004);
		bus(1, 8'h00, 16'h0009);
		bus(1, 8'h08, {13'h0000, md});
		tm[0].period <= 16'h0013;
		tm[0].run <= 1'b1;
		repeat (40) begin
			@(posedge clk_sys);
			h += (pin[0] === 1'b1);
			ev += (cirq[0] === 1'b1);
		end
		`CHK("pulse width", hi, h)
		`CHK("events", evx, ev)
	endtask : t_dual
	task automatic t_pwm;
		tm[0].run <= 1'b0;
		tm[0].period <= 16'h0009;
		bus(1, 8'h00, 16'h0003);
		bus(1, 8'h08, 16'h0006);
		tm[0].run <= 1'b1;
		bus(1, 8'h04, 16'h0007);
		do @(posedge clk_sys); while (tm[0].count !== 16'h0000);
		`CHK("timer flag", 1'b1, tirq[0])
		repeat (2) begin
			do @(posedge clk_sys); while (tm[0].count !== 16'h0001);
			`CHK("pwm set", 1'b1, pin[0])
			do @(posedge clk_sys); while (tm[0].count !== 16'h0004);
			`CHK("pwm clear", 1'b0, pin[0])
		end
		bus(0, 8'h04, 16'h0000);
		`CHK("duty latch", 32'h0000_0003, q)
	endtask : t_pwm
	task automatic t_fault;
		bus(1, 8'h08, 16'h0007);
		trip <= 1'b1;
		repeat (6) @(posedge clk_sys);
		`CHK("float", 1'b1, oe_n[0])
		`CHK("line", 1'b0, lvl0)
		bus(0, 8'h08, 16'h0000);
		`CHK("fault flag", 1'b1, q[4])
		trip <= 1'b0;
		repeat (6) @(posedge clk_sys);
		`CHK("still float", 1'b1, oe_n[0])
		bus(1, 8'h08, 16'h0007);
		@(posedge clk_sys);
		`CHK("driven", 1'b0, oe_n[0])
		bus(1, 8'h08, 16'h0000);
		@(posedge clk_sys);
		`CHK("off pin", 1'b0, pin[0])
	endtask : t_fault
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_single();
		t_dual(3'h4, 5, 2);
		t_dual(3'h5, 10, 4);
		t_pwm();
		t_fault();
		test_done();
	end
endmodule : tb_output_compare_pwm_channel
`default_nettype wire
